// >>> logic/vfb_pkg.sv
// Package: constants of the back-end decoder and output stage
package vfb_pkg;
	// ----------------------------------------------------------------
	// De-interleaver
	// ----------------------------------------------------------------
	localparam int          BRANCHES  = 52;
	localparam int          UNIT_DLY  = 4;
	localparam int          DI_MEM    = UNIT_DLY * BRANCHES * (BRANCHES - 1) / 2;
	localparam int          DI_AW     = 13;
	localparam int          PTR_W     = 11;
	localparam int          BR_W      = 6;
	// ----------------------------------------------------------------
	// Block code
	// ----------------------------------------------------------------
	localparam int          RS_N      = 207;
	localparam int          RS_K      = 187;
	localparam int          RS_T      = 10;
	localparam int          NSYN      = 2 * RS_T;
	localparam int          CNT_W     = 8;
	localparam int          BB_AW     = 9;
	localparam logic [7:0]  GF_POLY   = 8'h1D;
	// ----------------------------------------------------------------
	// Packet and de-randomizer
	// ----------------------------------------------------------------
	localparam logic [7:0]  SYNC_BYTE = 8'h47;
	localparam int          TEI_BIT   = 7;
	localparam logic [15:0] PRBS_INIT = 16'hF180;
	localparam logic [15:0] PRBS_TAPS = 16'h38CB;
	// ----------------------------------------------------------------
	// Output stage
	// ----------------------------------------------------------------
	localparam int          FIFO_D    = 4;
	localparam int          FIFO_W    = 10;

	typedef enum logic [1:0] {
		VFB_IDLE = 2'b00,
		VFB_SYNC = 2'b01,
		VFB_DATA = 2'b10
	} vfb_rd_t;
endpackage : vfb_pkg

// >>> logic/vfb_decoder.sv
// Back-end decoder: de-interleaver, block check, de-randomizer and stream output
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Stream FIFO
// ----------------------------------------------------------------
module vfb_fifo #(
	parameter int W = 10,
	parameter int D = 4
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         resetn,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0] mem [0:D-1];
	logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [AW:0]   cnt_r, cnt_nxt;
	logic          push, pop;

	assign in_ready  = (cnt_r != (AW+1)'(D));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem[rp_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		wp_nxt  = wp_r;
		rp_nxt  = rp_r;
		cnt_nxt = cnt_r;
		if (push)
			wp_nxt = (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
		if (pop)
			rp_nxt = (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
		if (push && !pop)
			cnt_nxt = cnt_r + 1'b1;
		else if (pop && !push)
			cnt_nxt = cnt_r - 1'b1;
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (push)
			mem[wp_r] <= in_data;
	end
endmodule : vfb_fifo

// ----------------------------------------------------------------
// Decoder top
// ----------------------------------------------------------------
module vfb_decoder
	import vfb_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       resetn,
	// Trellis decoder byte stream
	input  wire logic [7:0] trellis_byte,
	input  wire logic       trellis_valid,
	input  wire logic       trellis_field_start,
	// Transport stream out
	output logic            stream_out_clock,
	output logic      [7:0] stream_data,
	output logic            packet_start_flag,
	output logic            byte_valid_flag,
	output logic            block_error_flag
);
	import vfb_pkg::*;

	function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] p;
		logic [7:0] x;
		p = '0;
		x = a;
		for (int i = 0; i < 8; i++) begin
			if (b[i])
				p = p ^ x;
			x = {x[6:0], 1'b0} ^ (x[7] ? GF_POLY : 8'h00);
		end
		return p;
	endfunction : gf_mul

	function automatic logic [7:0] gf_root(input int n);
		logic [7:0] r;
		r = 8'h01;
		for (int i = 0; i < n; i++)
			r = gf_mul(r, 8'h02);
		return r;
	endfunction : gf_root

	function automatic logic [DI_AW-1:0] br_base(input logic [BR_W-1:0] j);
		int b;
		b = UNIT_DLY * (int'(j) * (BRANCHES - 1) - int'(j) * (int'(j) - 1) / 2);
		return DI_AW'(b);
	endfunction : br_base

	// Galois LFSR, eight shifts per byte; output byte taken before the shifts
	function automatic logic [15:0] prbs_step8(input logic [15:0] s);
		logic [15:0] v;
		v = s;
		for (int i = 0; i < 8; i++)
			v = v[15] ? ({v[14:0], 1'b0} ^ PRBS_TAPS) : {v[14:0], 1'b0};
		return v;
	endfunction : prbs_step8

	// ----------------------------------------------------------------
	// De-interleaver
	// ----------------------------------------------------------------
	// Branch j delays by UNIT_DLY*(BRANCHES-1-j); each branch but the last (no delay) is a ring in one array
	logic [7:0]       di_mem [0:DI_MEM-1];
	logic [PTR_W-1:0] ptr_r [0:BRANCHES-1];
	logic [PTR_W-1:0] ptr_nxt [0:BRANCHES-1];
	logic [BR_W-1:0]  br_r, br_nxt, br_cur;
	logic [PTR_W-1:0] br_len;
	logic [DI_AW-1:0] di_addr;
	logic [7:0]       di_byte;
	logic             di_wr;
	logic [BRANCHES-1:0] fill_r, fill_nxt;
	logic             di_cold;

	always_comb begin
		ptr_nxt = ptr_r;
		br_cur  = trellis_field_start ? '0 : br_r;
		br_len  = PTR_W'(UNIT_DLY * (BRANCHES - 1 - int'(br_cur)));
		di_addr = br_base(br_cur) + DI_AW'(ptr_r[br_cur]);
		di_wr   = trellis_valid && (br_len != '0);
		di_byte = (br_len == '0) ? trellis_byte : di_mem[di_addr];
		// Memory is not cleared: a slot read before its first write is garbage
		di_cold  = (br_len != '0) && !fill_r[br_cur];
		fill_nxt = fill_r;
		br_nxt  = br_r;
		if (trellis_valid) begin
			br_nxt = (br_cur == BR_W'(BRANCHES - 1)) ? '0 : br_cur + 1'b1;
			if (br_len != '0) begin
				ptr_nxt[br_cur] = (ptr_r[br_cur] == br_len - 1'b1) ? '0
					: ptr_r[br_cur] + 1'b1;
				if (ptr_r[br_cur] == br_len - 1'b1)
					fill_nxt[br_cur] = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			br_r   <= '0;
			fill_r <= '0;
			for (int i = 0; i < BRANCHES; i++)
				ptr_r[i] <= '0;
		end else begin
			br_r   <= br_nxt;
			ptr_r  <= ptr_nxt;
			fill_r <= fill_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (di_wr)
			di_mem[di_addr] <= trellis_byte;
	end

	// ----------------------------------------------------------------
	// Block check and ping-pong block buffer
	// ----------------------------------------------------------------
	logic [7:0]       bb_mem [0:2*RS_K-1];
	logic [7:0]       syn_r [0:NSYN-1];
	logic [7:0]       syn_nxt [0:NSYN-1];
	logic [CNT_W-1:0] bc_r, bc_nxt, bc_cur;
	logic             wb_r, wb_nxt;
	logic [1:0]       full_r, full_nxt, err_r, err_nxt, fld_r, fld_nxt;
	logic             fpend_r, fpend_nxt, blk_bad, bb_wr;
	logic [BB_AW-1:0] bb_waddr;
	logic             rd_done;
	logic             rb_r;
	logic             cold_r, cold_nxt;

	always_comb begin
		bc_cur    = trellis_field_start ? '0 : bc_r;
		fpend_nxt = fpend_r | (trellis_valid & trellis_field_start);
		bc_nxt    = bc_r;
		wb_nxt    = wb_r;
		full_nxt  = full_r;
		err_nxt   = err_r;
		fld_nxt   = fld_r;
		cold_nxt  = cold_r;
		if (trellis_valid)
			cold_nxt = ((bc_cur == '0) ? 1'b0 : cold_r) | di_cold;
		bb_waddr  = BB_AW'(int'(wb_r) * RS_K) + BB_AW'(bc_cur);
		bb_wr     = trellis_valid && (bc_cur < CNT_W'(RS_K));
		blk_bad   = 1'b0;
		for (int i = 0; i < NSYN; i++) begin
			syn_nxt[i] = (bc_cur == '0) ? di_byte
				: gf_mul(syn_r[i], gf_root(i)) ^ di_byte;
			blk_bad = blk_bad | (syn_nxt[i] != '0);
		end
		if (rd_done)
			full_nxt[rb_r] = 1'b0;
		if (trellis_valid) begin
			bc_nxt = (bc_cur == CNT_W'(RS_N - 1)) ? '0 : bc_cur + 1'b1;
			if (bc_cur == CNT_W'(RS_N - 1)) begin
				// Set wins over the reader's clear on the same bank
				full_nxt[wb_r] = 1'b1;
				// Blocks read from unfilled rings count as uncorrectable
				err_nxt[wb_r]  = blk_bad | cold_nxt;
				fld_nxt[wb_r]  = fpend_nxt;
				fpend_nxt      = 1'b0;
				wb_nxt         = ~wb_r;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bc_r    <= '0;
			wb_r    <= 1'b0;
			full_r  <= '0;
			err_r   <= '0;
			fld_r   <= '0;
			fpend_r <= 1'b0;
			cold_r  <= 1'b0;
			for (int i = 0; i < NSYN; i++)
				syn_r[i] <= '0;
		end else begin
			bc_r    <= bc_nxt;
			wb_r    <= wb_nxt;
			full_r  <= full_nxt;
			err_r   <= err_nxt;
			fld_r   <= fld_nxt;
			fpend_r <= fpend_nxt;
			cold_r  <= cold_nxt;
			if (trellis_valid)
				syn_r <= syn_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (bb_wr)
			bb_mem[bb_waddr] <= di_byte;
	end

	// ----------------------------------------------------------------
	// Packet reader and de-randomizer
	// ----------------------------------------------------------------
	vfb_rd_t          st_r, st_nxt;
	logic             rb_nxt;
	logic [CNT_W-1:0] idx_r, idx_nxt;
	logic [15:0]      prbs_r, prbs_nxt;
	logic [7:0]       rd_byte;
	logic             f_valid, f_ready;
	logic [FIFO_W-1:0] f_in;

	always_comb begin
		st_nxt   = st_r;
		rb_nxt   = rb_r;
		idx_nxt  = idx_r;
		prbs_nxt = prbs_r;
		rd_done  = 1'b0;
		f_valid  = 1'b0;
		rd_byte  = bb_mem[BB_AW'(int'(rb_r) * RS_K) + BB_AW'(idx_r)] ^ prbs_r[15:8];
		if (idx_r == '0 && err_r[rb_r])
			rd_byte[TEI_BIT] = 1'b1;
		f_in = {SYNC_BYTE, 1'b1, err_r[rb_r]};
		case (st_r)
			VFB_IDLE: begin
				if (full_r[rb_r])
					st_nxt = VFB_SYNC;
			end
			VFB_SYNC: begin
				f_valid = 1'b1;
				if (f_ready) begin
					st_nxt  = VFB_DATA;
					idx_nxt = '0;
					if (fld_r[rb_r])
						prbs_nxt = PRBS_INIT;
				end
			end
			VFB_DATA: begin
				f_valid = 1'b1;
				f_in    = {rd_byte, 1'b0, err_r[rb_r]};
				if (f_ready) begin
					prbs_nxt = prbs_step8(prbs_r);
					idx_nxt  = idx_r + 1'b1;
					if (idx_r == CNT_W'(RS_K - 1)) begin
						rd_done = 1'b1;
						rb_nxt  = ~rb_r;
						st_nxt  = VFB_IDLE;
					end
				end
			end
			default: st_nxt = VFB_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			st_r   <= VFB_IDLE;
			rb_r   <= 1'b0;
			idx_r  <= '0;
			prbs_r <= PRBS_INIT;
		end else begin
			st_r   <= st_nxt;
			rb_r   <= rb_nxt;
			idx_r  <= idx_nxt;
			prbs_r <= prbs_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Output FIFO and stream port
	// ----------------------------------------------------------------
	// Bytes change on the falling edge of the data clock, so the far side
	// samples on the rising edge with half a period of setup
	logic              o_valid, o_pop, div_r, div_nxt;
	logic [FIFO_W-1:0] o_data;
	logic [7:0]        sd_nxt;
	logic              ps_nxt, bv_nxt, be_nxt;

	vfb_fifo #(
		.W (FIFO_W),
		.D (FIFO_D)
	) u_fifo (
		.clock     (clock),
		.resetn    (resetn),
		.in_valid  (f_valid),
		.in_ready  (f_ready),
		.in_data   (f_in),
		.out_valid (o_valid),
		.out_ready (o_pop),
		.out_data  (o_data)
	);

	always_comb begin
		div_nxt = ~div_r;
		o_pop   = div_r & o_valid;
		sd_nxt  = stream_data;
		ps_nxt  = packet_start_flag;
		bv_nxt  = byte_valid_flag;
		be_nxt  = block_error_flag;
		if (div_r) begin
			bv_nxt = o_valid;
			sd_nxt = o_valid ? o_data[9:2] : 8'h00;
			ps_nxt = o_valid & o_data[1];
			be_nxt = o_valid & o_data[0];
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			div_r             <= 1'b0;
			stream_data       <= 8'h00;
			packet_start_flag <= 1'b0;
			byte_valid_flag   <= 1'b0;
			block_error_flag  <= 1'b0;
		end else begin
			div_r             <= div_nxt;
			stream_data       <= sd_nxt;
			packet_start_flag <= ps_nxt;
			byte_valid_flag   <= bv_nxt;
			block_error_flag  <= be_nxt;
		end
	end

	assign stream_out_clock = div_r;
endmodule : vfb_decoder

// >>> dv/vfb_decoder_assertions.sv
// Checker: timing and framing properties of the transport stream outputs
`timescale 1ns/1ps
module vfb_decoder_chk
	import vfb_pkg::*;
(
	// Clock and reset
	input wire logic       clock,
	input wire logic       resetn,
	// Transport stream out
	input wire logic       stream_out_clock,
	input wire logic [7:0] stream_data,
	input wire logic       packet_start_flag,
	input wire logic       byte_valid_flag,
	input wire logic       block_error_flag
);
	// ----------------------------------------------------------------
	// Packet span counter: 188 bytes of two cycles each
	// ----------------------------------------------------------------
	logic [8:0] run_r;
	logic [8:0] run_nxt;
	logic       ps_r;
	logic       in_pkt;
	always_comb begin
		run_nxt = (run_r == 9'h000 || run_r == 9'h178) ? 9'h000 : run_r + 9'h001;
		if (packet_start_flag && !ps_r) begin
			run_nxt = 9'h001;
		end
	end
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			run_r <= 9'h000;
			ps_r  <= 1'b0;
		end else begin
			run_r <= run_nxt;
			ps_r  <= packet_start_flag;
		end
	end
	assign in_pkt = run_r != 9'h000 && run_r != 9'h178;
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	property p_clk_div; $past(resetn) |-> stream_out_clock != $past(stream_out_clock); endproperty
	a_clk_div: assert property (p_clk_div) else $error("data clock stalled");
	property p_data_edge; $changed(stream_data) |-> $fell(stream_out_clock); endproperty
	a_data_edge: assert property (p_data_edge) else $error("byte moved off edge");
	property p_flag_edge;
		$changed({packet_start_flag, byte_valid_flag, block_error_flag}) |-> $fell(stream_out_clock);
	endproperty
	a_flag_edge: assert property (p_flag_edge) else $error("flag moved off edge");
	property p_sync; packet_start_flag |-> byte_valid_flag && stream_data == SYNC_BYTE; endproperty
	a_sync: assert property (p_sync) else $error("start flag not on sync byte");
	property p_tei;
		$rose(packet_start_flag) && block_error_flag |-> ##2 stream_data[TEI_BIT] && block_error_flag;
	endproperty
	a_tei: assert property (p_tei) else $error("error bit not set in header");
	property p_gap; in_pkt |-> byte_valid_flag; endproperty
	a_gap: assert property (p_gap) else $error("gap inside packet");
	property p_len; $rose(packet_start_flag) |-> run_r == 9'h000 || run_r == 9'h178; endproperty
	a_len: assert property (p_len) else $error("packet too short");
	property p_err_hold; in_pkt |-> $stable(block_error_flag); endproperty
	a_err_hold: assert property (p_err_hold) else $error("error flag moved in packet");
	property p_valid_phase; $rose(byte_valid_flag) |-> !stream_out_clock; endproperty
	a_valid_phase: assert property (p_valid_phase) else $error("valid rose off edge");
	c_pkt: cover property ($rose(packet_start_flag));
	c_bad: cover property ($rose(packet_start_flag) && block_error_flag);
	c_back: cover property ($rose(packet_start_flag) && run_r == 9'h178);
endmodule : vfb_decoder_chk

bind vfb_decoder vfb_decoder_chk u_chk (.clock(clock), .resetn(resetn),
	.stream_out_clock(stream_out_clock), .stream_data(stream_data),
	.packet_start_flag(packet_start_flag), .byte_valid_flag(byte_valid_flag),
	.block_error_flag(block_error_flag));

// >>> dv/vfb_demux_model.sv
// Demultiplexer model: takes packets on the data clock and judges their content
`timescale 1ns/1ps
module vfb_demux_model
	import vfb_pkg::*;
(
	// Transport stream in
	input wire logic       stream_out_clock,
	input wire logic [7:0] stream_data,
	input wire logic       packet_start_flag,
	input wire logic       byte_valid_flag,
	input wire logic       block_error_flag,
	// Tallies
	output int             good_cnt,
	output int             bad_cnt,
	output int             bad_bytes,
	output int             good_run
);
	logic [15:0] prbs;
	logic        err;
	int          idx;
	initial begin
		{good_cnt, bad_cnt, bad_bytes, good_run, idx} = '0;
	end
	// Every packet must carry a known error flag, warm-up packets included
	always @(posedge stream_out_clock) begin
		if (byte_valid_flag === 1'b1) begin
			if (packet_start_flag === 1'b1) begin
				if (idx != 0 && idx != 188) bad_bytes++;
				if (stream_data !== SYNC_BYTE) bad_bytes++;
				err = block_error_flag;
				if (err !== 1'b0 && err !== 1'b1) bad_bytes++;
				prbs = PRBS_INIT;
				idx = 1;
				if (err === 1'b1) begin
					bad_cnt++;
					good_run = 0;
				end
				if (err === 1'b0) begin
					good_cnt++;
					good_run++;
				end
			end else if (idx > 0) begin
				if (idx == 1 && err === 1'b1 && stream_data[TEI_BIT] !== 1'b1) bad_bytes++;
				if (err === 1'b0 && stream_data !== prbs[15:8]) bad_bytes++;
				for (int i = 0; i < 8; i++) begin
					prbs = prbs[15] ? {prbs[14:0], 1'b0} ^ PRBS_TAPS : {prbs[14:0], 1'b0};
				end
				idx++;
			end
		end
	end
endmodule : vfb_demux_model

// >>> dv/vfb_decoder_tb.sv
// Testbench: feeds blocks to the decoder and judges the transport stream
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module vfb_decoder_tb;
	logic       clock = 1'b0;
	logic       resetn = 1'b0;
	logic [7:0] trellis_byte = 8'h00;
	logic       trellis_valid = 1'b0;
	logic       trellis_field_start = 1'b0;
	logic       stream_out_clock;
	logic [7:0] stream_data;
	logic       packet_start_flag;
	logic       byte_valid_flag;
	logic       block_error_flag;
	int         good_cnt, bad_cnt, bad_bytes, good_run;
	int         n_fail = 0;
	int         checks = 0;
	always #25 clock = ~clock;
	vfb_decoder DUT (.clock(clock), .resetn(resetn), .trellis_byte(trellis_byte),
		.trellis_valid(trellis_valid), .trellis_field_start(trellis_field_start),
		.stream_out_clock(stream_out_clock), .stream_data(stream_data),
		.packet_start_flag(packet_start_flag), .byte_valid_flag(byte_valid_flag),
		.block_error_flag(block_error_flag));
	vfb_demux_model demux (.stream_out_clock(stream_out_clock), .stream_data(stream_data),
		.packet_start_flag(packet_start_flag), .byte_valid_flag(byte_valid_flag),
		.block_error_flag(block_error_flag), .good_cnt(good_cnt), .bad_cnt(bad_cnt),
		.bad_bytes(bad_bytes), .good_run(good_run));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// One byte every third cycle keeps the input below the output byte rate
	task automatic feed(input int nblk, input logic [7:0] val);
		for (int b = 0; b < nblk; b++) begin
			for (int i = 0; i < vfb_pkg::RS_N; i++) begin
				@(negedge clock);
				trellis_valid = 1'b1;
				trellis_byte = val;
				trellis_field_start = (i == 0);
				@(negedge clock);
				trellis_valid = 1'b0;
				@(negedge clock);
			end
		end
		repeat (400) @(negedge clock);
	endtask : feed
	task automatic test_clean;
		feed(58, 8'h00);
		`CHK("clean packets", 1'b1, good_cnt > 0)
		`CHK("warm-up packets", vfb_pkg::BRANCHES - 1, bad_cnt)
		`CHK("first clean packets", 58 - (vfb_pkg::BRANCHES - 1), good_cnt)
		`CHK("byte faults", 0, bad_bytes)
		$display("clean stream test done");
	endtask : test_clean
	// Several bad blocks in a row so all spread blocks but the first two and last two hold more than ten errors
	task automatic test_corrupt;
		int b0;
		b0 = bad_cnt;
		feed(4, 8'hA5);
		feed(8, 8'h00);
		`CHK("bad packets", 1'b1, bad_cnt > b0)
		`CHK("byte faults", 0, bad_bytes)
		$display("corrupt block test done");
	endtask : test_corrupt
	task automatic test_recover;
		feed(56, 8'h00);
		`CHK("good run", 1'b1, good_run > 0)
		`CHK("byte faults", 0, bad_bytes)
		$display("recovery test done");
	endtask : test_recover
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (2) @(negedge clock);
		`CHK("reset outputs", 12'h000, {stream_out_clock, stream_data, packet_start_flag,
			byte_valid_flag, block_error_flag})
		$display("reset test done");
		resetn = 1'b1;
		test_clean();
		test_corrupt();
		test_recover();
		tally_and_finish();
	end
	initial begin
		#5_000_000;
		n_fail++;
		tally_and_finish();
	end
endmodule : vfb_decoder_tb
